//--- hw/sar_adc_control.v
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "sar_adc_control_map.vh"

// Overview of operation
// - Codes 0-5 select port pins; 6-28 reserved
// - All-ones channel code powers converter off
// - Codes 29/30 select high/low reference nodes
// - Selected pin forced input; others normal GPIO
// - Port writes ignored on selected pin
// - Port read of selected pin returns zero
// - Full scale FF, zero 00, saturating linear
// - Control write starts 16-17 tick conversion
// - Continuous mode overwrites result, keeps converting
// - Continuous complete flag holds until write/read
// - Single mode: one conversion per write
// - With irq off, complete flag set on done, cleared write/read
// - With irq enabled bit selects CPU/DMA
// - Interrupt at conversion end, drop on read/write
// - Reset clears enable, continuous, complete bits
// - Keeps converting in wait; irq wakes
// - Stop aborts conversion, resumes on exit
// - Single 8-bit result loaded per conversion
module sar_adc_control #(
   parameter NUM_PINS = 6
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // External converter clock source, one-cycle enable
   input wire ext_clk_en,
   // Power modes
   input wire wait_mode,
   input wire stop_mode,
   // Analog front end
   output wire [4:0] mux_select,
   output wire converter_power,
   output wire [7:0] dac_code,
   input wire comp_above,
   // Port pin sharing
   input wire [NUM_PINS-1:0] port_data,
   input wire [NUM_PINS-1:0] port_dir,
   output wire [NUM_PINS-1:0] port_read,
   input wire [NUM_PINS-1:0] analog_port_pins_in,
   output wire [NUM_PINS-1:0] analog_port_pins_out,
   output wire [NUM_PINS-1:0] analog_port_pins_oe,
   // Service requests
   output wire cpu_irq,
   output wire dma_req,
   output wire wake_req
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SYNC = 3'b010;
   localparam ST_CONV = 3'b100;
   // Reset words narrowed to their fields
   localparam [7:0] CS_RST = `CS_RESET;
   localparam [7:0] CLK_RST = `CLK_RESET;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [4:0] chan_reg;
   reg cont_reg;
   reg irq_en_reg;
   reg complete_reg;
   reg complete_next;
   reg [2:0] div_reg;
   reg src_reg;
   reg [7:0] result_reg;
   reg [7:0] trial_reg;
   reg [7:0] trial_next;
   reg [4:0] cnt_reg;
   reg [4:0] cnt_next;
   reg [3:0] div_cnt_reg;
   reg irq_pend_reg;
   reg irq_pend_next;
   reg resume_reg;
   reg resume_next;
   reg stop_d_reg;
   reg dp_write_reg;
   reg dp_read_reg;
   reg [7:0] dp_addr_reg;
   reg [3:0] div_limit;
   reg [NUM_PINS-1:0] pin_hit;
   reg [31:0] rdata;
   integer i;

   wire ap_valid;
   wire cs_write;
   wire res_read;
   wire clk_write;
   wire src_en;
   wire adc_tick;
   wire powered;
   wire pin_chan;
   wire ref_chan;
   wire reserved_chan;
   wire comp_ok;
   wire conv_done;
   wire stop_exit;
   wire new_irq_en;
   wire [2:0] bit_idx;

   // AHB address phase capture
   assign ap_valid = hsel & hready & htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_reg <= 1'b0;
         dp_read_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         if (hready) begin
            dp_write_reg <= ap_valid & hwrite;
            dp_read_reg <= ap_valid & ~hwrite;
            dp_addr_reg <= haddr[7:0];
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cs_write = dp_write_reg & (dp_addr_reg == `ADC_CTRL_STATUS_OFF);
   assign clk_write = dp_write_reg & (dp_addr_reg == `ADC_CLOCK_OFF);
   assign res_read = dp_read_reg & (dp_addr_reg == `ADC_RESULT_OFF);
   assign new_irq_en = hwdata[`CS_IRQ_EN_BIT];

   always @* begin
      rdata = 32'h00000000;
      case (dp_addr_reg)
         `ADC_CTRL_STATUS_OFF: rdata[7:0] = {complete_reg, irq_en_reg, cont_reg, chan_reg};
         `ADC_RESULT_OFF: rdata[7:0] = result_reg;
         `ADC_CLOCK_OFF: rdata[7:0] = {3'h0, src_reg, 1'b0, div_reg};
         default: rdata = 32'h00000000;
      endcase
   end

   // Zero outside a read data phase
   assign hrdata = dp_read_reg ? rdata : 32'h00000000;

   // Channel decode
   // pin channel decode
   assign pin_chan = (chan_reg <= `CHAN_PIN_LAST);
   assign ref_chan = (chan_reg == `CHAN_REF_HIGH) | (chan_reg == `CHAN_REF_LOW);
   assign reserved_chan = ~pin_chan & ~ref_chan;
   assign powered = (chan_reg != `CHAN_POWER_OFF) & ~stop_mode;
   assign converter_power = powered;
   assign mux_select = chan_reg;
   assign comp_ok = comp_above & ~reserved_chan;

   // Port pin override
   always @* begin
      for (i = 0; i < NUM_PINS; i = i + 1) begin
         pin_hit[i] = pin_chan & (chan_reg == i[4:0]);
      end
   end

   assign analog_port_pins_oe = port_dir & ~pin_hit;
   // port writes blocked on selected pin
   assign analog_port_pins_out = port_data & ~pin_hit;
   assign port_read = analog_port_pins_in & ~pin_hit;

   // Converter clock divider, ratios 1/2/4/8/16
   always @* begin
      case (div_reg)
         3'h0: div_limit = 4'h0;
         3'h1: div_limit = 4'h1;
         3'h2: div_limit = 4'h3;
         3'h3: div_limit = 4'h7;
         default: div_limit = 4'hf;
      endcase
   end

   assign src_en = src_reg ? 1'b1 : ext_clk_en;
   assign adc_tick = src_en & (div_cnt_reg >= div_limit);

   // Divider parked while converter is off
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg <= 4'h0;
      end else if (!powered) begin
         div_cnt_reg <= 4'h0;
      end else if (src_en) begin
         if (div_cnt_reg >= div_limit) begin
            div_cnt_reg <= 4'h0;
         end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
         end
      end
   end

   // Conversion sequencer
   assign conv_done = (state_reg == ST_CONV) & adc_tick & (cnt_reg == `CONV_TICKS - 5'h1);
   // Stop exit seen in the first cycle that stop_mode is low
   assign stop_exit = stop_d_reg & ~stop_mode;
   assign bit_idx = 3'h7 - cnt_reg[2:0];
   assign dac_code = trial_reg;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cs_write & (hwdata[4:0] != `CHAN_POWER_OFF)) begin
               state_next = ST_SYNC;
            end else if (stop_exit & powered & (resume_reg | cont_reg)) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (adc_tick) begin
               state_next = ST_CONV;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               state_next = cont_reg ? ST_SYNC : ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // A control write restarts the sequence, or idles it on the power-off code
      if (cs_write & (state_reg != ST_IDLE)) begin
         state_next = (hwdata[4:0] != `CHAN_POWER_OFF) ? ST_SYNC : ST_IDLE;
      end
      if (stop_mode | ~powered & ~cs_write) begin
         state_next = ST_IDLE;
      end
   end

   // Successive approximation datapath
   always @* begin
      cnt_next = cnt_reg;
      trial_next = trial_reg;
      if (state_next == ST_SYNC) begin
         cnt_next = 5'h00;
         trial_next = 8'h80;
      end else if ((state_reg == ST_CONV) & adc_tick) begin
         cnt_next = cnt_reg + 5'h1;
         if (cnt_reg < `SAR_BITS) begin
            if (!comp_ok) begin
               trial_next[bit_idx] = 1'b0;
            end
            if (cnt_reg < `SAR_BITS - 5'h1) begin
               trial_next[bit_idx - 3'h1] = 1'b1;
            end
         end
      end
   end

   // Stop resume bookkeeping
   always @* begin
      resume_next = resume_reg;
      if (stop_mode & (state_reg != ST_IDLE)) begin
         resume_next = 1'b1;
      end else if (stop_exit | cs_write) begin
         resume_next = 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 5'h00;
         trial_reg <= 8'h00;
         result_reg <= `RESULT_RESET;
         resume_reg <= 1'b0;
         stop_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         stop_d_reg <= stop_mode;
         resume_reg <= resume_next;
         cnt_reg <= cnt_next;
         trial_reg <= trial_next;
         if (conv_done) begin
            result_reg <= trial_reg;
         end
      end
   end

   // Clock register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= CLK_RST[2:0];
         src_reg <= 1'b0;
      end else if (clk_write) begin
         div_reg <= hwdata[`CLK_DIV_MSB:`CLK_DIV_LSB];
         src_reg <= hwdata[`CLK_SRC_BIT];
      end
   end

   // Flag and request; completion wins over a clear, except a write that sets irq enable
   always @* begin
      complete_next = complete_reg;
      irq_pend_next = irq_pend_reg;
      if (conv_done & ~irq_en_reg & ~(cs_write & new_irq_en)) begin
         complete_next = 1'b1;
      end else if (cs_write) begin
         complete_next = new_irq_en ? hwdata[`CS_COMPLETE_BIT] : 1'b0;
      end else if (res_read & ~irq_en_reg) begin
         complete_next = 1'b0;
      end
      if (conv_done & irq_en_reg) begin
         irq_pend_next = 1'b1;
      end else if (cs_write | res_read) begin
         irq_pend_next = 1'b0;
      end
   end

   // Control/status register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_reg <= CS_RST[4:0];
         cont_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         complete_reg <= 1'b0;
         irq_pend_reg <= 1'b0;
      end else begin
         if (cs_write) begin
            chan_reg <= hwdata[`CS_CHAN_MSB:`CS_CHAN_LSB];
            cont_reg <= hwdata[`CS_CONT_BIT];
            irq_en_reg <= new_irq_en;
         end
         complete_reg <= complete_next;
         irq_pend_reg <= irq_pend_next;
      end
   end

   assign cpu_irq = irq_pend_reg & irq_en_reg & ~complete_reg;
   assign dma_req = irq_pend_reg & irq_en_reg & complete_reg;
   assign wake_req = cpu_irq & wait_mode;

endmodule // sar_adc_control

//--- hw/sar_adc_control_map.vh
`ifndef SAR_ADC_CONTROL_MAP_VH
`define SAR_ADC_CONTROL_MAP_VH

// Register byte offsets
`define ADC_CTRL_STATUS_OFF 8'h00
`define ADC_RESULT_OFF 8'h04
`define ADC_CLOCK_OFF 8'h08

// Control/status fields
`define CS_COMPLETE_BIT 7
`define CS_IRQ_EN_BIT 6
`define CS_CONT_BIT 5
`define CS_CHAN_MSB 4
`define CS_CHAN_LSB 0

// Clock register fields
`define CLK_DIV_MSB 2
`define CLK_DIV_LSB 0
`define CLK_SRC_BIT 4

// Reset values
`define CS_RESET 8'h1f
`define CLK_RESET 8'h00
`define RESULT_RESET 8'h00

// Channel codes
`define CHAN_PIN_LAST 5'h05
`define CHAN_REF_HIGH 5'h1d
`define CHAN_REF_LOW 5'h1e
`define CHAN_POWER_OFF 5'h1f

// Converter clock ticks per conversion after the sync tick
`define CONV_TICKS 5'h10
`define SAR_BITS 5'h08

`endif

//--- tb/analog_front_model.sv
`timescale 1ns/10ps
module analog_front_model (
   // Converter side
   input wire [4:0] mux_select,
   input wire converter_power,
   input wire [7:0] dac_code,
   output wire comp_above,
   // Pads
   input wire [5:0] pins_out,
   input wire [5:0] pins_oe,
   input wire [5:0] pins_ext,
   output wire [5:0] pins_in
);
   reg [7:0] level;
   always @* begin
      if (mux_select < 5'h06)
         level = {mux_select, 3'h3};
      else if (mux_select == 5'h1d)
         level = 8'hff;
      else
         level = 8'h00;
   end
   // Unpowered comparator output is junk
   assign comp_above = converter_power ? (level >= dac_code) : ~dac_code[0];
   assign pins_in = (pins_out & pins_oe) | (pins_ext & ~pins_oe);
endmodule // analog_front_model

//--- tb/sar_adc_control_props.sv
`timescale 1ns/10ps
module sar_adc_control_props #(
   parameter NUM_PINS = 6
) (
   // Clock, reset, modes
   input wire hclk,
   input wire hresetn,
   input wire wait_mode,
   input wire stop_mode,
   // Converter and requests
   input wire [4:0] mux_select,
   input wire converter_power,
   input wire cpu_irq,
   input wire dma_req,
   input wire wake_req,
   // Port pin sharing
   input wire [NUM_PINS-1:0] port_data,
   input wire [NUM_PINS-1:0] port_dir,
   input wire [NUM_PINS-1:0] port_read,
   input wire [NUM_PINS-1:0] analog_port_pins_in,
   input wire [NUM_PINS-1:0] analog_port_pins_out,
   input wire [NUM_PINS-1:0] analog_port_pins_oe
);
   wire [NUM_PINS-1:0] sel_mask;
   assign sel_mask = (mux_select < NUM_PINS) ?
      ({{(NUM_PINS-1){1'b0}}, 1'b1} << mux_select) : {NUM_PINS{1'b0}};
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_power_off;
      mux_select == 5'h1f |-> !converter_power;
   endproperty
   a_power_off: assert property (p_power_off) else $error("power on while off");
   property p_stop_off;
      stop_mode |-> !converter_power;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("power on in stop");
   property p_pin_dir;
      analog_port_pins_oe == (port_dir & ~sel_mask);
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pad enable wrong");
   property p_pin_drive;
      analog_port_pins_out == (port_data & ~sel_mask);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pad drive wrong");
   property p_pin_read;
      port_read == (analog_port_pins_in & ~sel_mask);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("port read wrong");
   property p_one_service;
      !(cpu_irq && dma_req);
   endproperty
   a_one_service: assert property (p_one_service) else $error("both requests");
   property p_wake;
      wake_req == (cpu_irq && wait_mode);
   endproperty
   a_wake: assert property (p_wake) else $error("wake wrong");
   property p_reset_quiet;
      $rose(hresetn) |-> !cpu_irq && !dma_req && !converter_power;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
endmodule // sar_adc_control_props

bind sar_adc_control sar_adc_control_props #(.NUM_PINS(NUM_PINS)) u_props (
   .hclk(hclk), .hresetn(hresetn), .wait_mode(wait_mode), .stop_mode(stop_mode),
   .mux_select(mux_select), .converter_power(converter_power), .cpu_irq(cpu_irq),
   .dma_req(dma_req), .wake_req(wake_req), .port_data(port_data), .port_dir(port_dir),
   .port_read(port_read), .analog_port_pins_in(analog_port_pins_in),
   .analog_port_pins_out(analog_port_pins_out), .analog_port_pins_oe(analog_port_pins_oe));

//--- tb/sar_adc_control_tb.sv
`timescale 1ns/10ps
module sar_adc_control_tb;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg wait_mode = 1'b0;
   reg stop_mode = 1'b0;
   reg ext_clk_en = 1'b0;
   reg [2:0] ext_div = 3'h0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, comp_above, converter_power, cpu_irq, dma_req, wake_req;
   wire [4:0] mux_select;
   wire [7:0] dac_code;
   wire [5:0] pins_in, pins_out, pins_oe;
   integer n_mismatch = 0;
   integer samples_checked = 0;
   integer i;
   reg [31:0] rd;
   reg [4:0] ch;
   always #50 hclk = ~hclk;
   // External converter clock stand-in, one pulse in eight
   always @(posedge hclk) begin
      ext_div <= ext_div + 3'h1;
      ext_clk_en <= (ext_div == 3'h7);
   end
   sar_adc_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clk_en(ext_clk_en),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .mux_select(mux_select),
      .converter_power(converter_power), .dac_code(dac_code), .comp_above(comp_above),
      .port_data(6'h2a), .port_dir(6'h3c), .port_read(), .analog_port_pins_in(pins_in),
      .analog_port_pins_out(pins_out), .analog_port_pins_oe(pins_oe), .cpu_irq(cpu_irq),
      .dma_req(dma_req), .wake_req(wake_req));
   analog_front_model partner (.mux_select(mux_select), .converter_power(converter_power),
      .dac_code(dac_code), .comp_above(comp_above), .pins_out(pins_out), .pins_oe(pins_oe),
      .pins_ext(6'h15), .pins_in(pins_in));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked++;
         if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task ready_edge;
      integer k;
      begin
         k = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1 && k < 20) begin
            @(posedge hclk);
            k++;
         end
         if (hreadyout !== 1'b1) begin
            n_mismatch++;
            conclude;
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [7:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= {24'h0, a};
         hwrite <= w;
         ready_edge;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= {24'h0, d};
         ready_edge;
         rd = hrdata;
      end
   endtask
   task wait_done;
      integer k;
      begin
         k = 0;
         rd = 32'h0;
         while (rd[7] !== 1'b1 && k < 200) begin
            bus(1'b0, 8'h0, 8'h0);
            k++;
         end
         if (rd[7] !== 1'b1) begin
            n_mismatch++;
            conclude;
         end
         check(rd[7], 32'h1);
      end
   endtask
   function [7:0] code_of(input [4:0] c);
      code_of = (c < 5'h06) ? {c, 3'h3} : ((c == 5'h1d) ? 8'hff : 8'h00);
   endfunction
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h0, 8'h0);
      check({hresp, cpu_irq, dma_req, rd[28:0]}, 32'h1f);
      bus(1'b0, 8'h4, 8'h0);
      check(rd, 32'h0);
      bus(1'b0, 8'h8, 8'h0);
      check(rd, 32'h0);
      bus(1'b0, 8'hc, 8'h0);
      check(rd, 32'h0);
      bus(1'b1, 8'h0, 8'h00);
      wait_done;
      // hclk over 8, near 1 MHz
      bus(1'b1, 8'h8, 8'h13);
      bus(1'b0, 8'h8, 8'h0);
      check(rd, 32'h13);
      for (i = 0; i < 10; i++) begin
         ch = (i < 6) ? i[4:0] : ((i == 6) ? 5'h07 : i[4:0] + 5'h15);
         bus(1'b1, 8'h0, {3'h0, ch});
         wait_done;
         bus(1'b0, 8'h4, 8'h0);
         check(rd, {24'h0, code_of(ch)});
         bus(1'b0, 8'h0, 8'h0);
         check(rd, {27'h0, ch});
      end
      repeat (200) @(posedge hclk);
      bus(1'b0, 8'h0, 8'h0);
      check(rd, 32'h1e);
      bus(1'b1, 8'h0, 8'h22);
      wait_done;
      check(rd, 32'ha2);
      bus(1'b0, 8'h4, 8'h0);
      check(rd, 32'h13);
      wait_done;
      wait_mode <= 1'b1;
      bus(1'b1, 8'h0, 8'h44);
      i = 0;
      while (cpu_irq !== 1'b1 && i < 400) begin
         @(posedge hclk);
         i++;
      end
      if (cpu_irq !== 1'b1) begin
         n_mismatch++;
         conclude;
      end
      check({wake_req, dma_req, cpu_irq}, 32'h5);
      bus(1'b0, 8'h0, 8'h0);
      check(rd, 32'h44);
      bus(1'b0, 8'h4, 8'h0);
      check(rd, 32'h23);
      @(posedge hclk);
      check(cpu_irq, 32'h0);
      wait_mode <= 1'b0;
      bus(1'b1, 8'h0, 8'h02);
      stop_mode <= 1'b1;
      repeat (200) @(posedge hclk);
      bus(1'b0, 8'h0, 8'h0);
      check(rd, 32'h02);
      stop_mode <= 1'b0;
      wait_done;
      bus(1'b0, 8'h4, 8'h0);
      check(rd, 32'h13);
      conclude;
   end
endmodule // sar_adc_control_tb
